// *** hdl/sample_buffer.sv ***
// Small valid/ready FIFO that decouples the coder from a stalling receiver.
module sample_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             wr_valid_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  wr_ready_o,
	// Drain side
	output logic                  rd_valid_o,
	output logic [WIDTH-1:0]      rd_data_o,
	input  wire logic             rd_ready_i
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("sample_buffer DEPTH must be a power of two of at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} buf_type;

	buf_type r;
	buf_type n;
	logic    push;
	logic    pop;

	assign wr_ready_o = (r.cnt != (AW+1)'(DEPTH));
	assign rd_valid_o = (r.cnt != '0);
	assign rd_data_o  = r.mem[r.rp];
	assign push       = wr_valid_i && wr_ready_o;
	assign pop        = rd_valid_o && rd_ready_i;

	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = wr_data_i;
			n.wp        = r.wp + 1'b1;
		end
		if (pop) begin
			n.rp = r.rp + 1'b1;
		end
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule : sample_buffer

// *** hdl/transcoder_pkg.sv ***
// Shared formats, companding constants, coder state types and rule summary.
// Contract
// [R01] Mu-law: 14-bit linear to 8-bit code and back
// [R02] A-law: 13-bit linear to 8-bit code and back
// [R03] Companding is memoryless, one sample each
// [R04] A-law codes XORed with 0x55 mask
// [R05] Mu-law codes XORed with all-ones mask
// [R06] Companded: one byte per 8 kHz sample
// [R07] Slope-delta encoder filters input before comparing
// [R08] Emit one and add step, else zero
// [R09] Step grows on three equal bits
// [R10] Reference accumulator is a leaky integrator
// [R11] Decoder tracks reference, then output filter
// [R12] Slope-delta: one bit per 16 kHz sample
// [R13] Silence maps to alternating ones and zeros
// [R14] Decode to linear, convert, then encode
// [R15] Optional interpolate or decimate by two
// [R16] Compressed 8 kHz, linear 8 or 16
// [R17] Prediction decoder: 80 bits to 80 samples
// [R18] Prediction encoder: 80 samples to 80 bits
// [R19] Synthesis filtering then postfilter on decode
// [R20] Decoder monitor tap, switchable off
// [R21] Converter output also feeds activity detector
// [R22] Duplex second channel is reverse conversion
// [R23] Coded frame is five 16-bit words
// [R24] Coders follow the published recommendations
// [R25] Rate converter has fixed low-pass filtering
package transcoder_pkg;

	localparam logic [2:0] FMT_LIN  = 3'h0;
	localparam logic [2:0] FMT_ULAW = 3'h1;
	localparam logic [2:0] FMT_ALAW = 3'h2;
	localparam logic [2:0] FMT_CVSD = 3'h3;
	localparam logic [2:0] FMT_G729 = 3'h4;

	localparam logic [1:0] SRC_NONE   = 2'h0;
	localparam logic [1:0] SRC_INTERP = 2'h1;
	localparam logic [1:0] SRC_DECIM  = 2'h2;

	localparam logic [7:0]  MU_MASK  = 8'hFF;
	localparam logic [7:0]  A_MASK   = 8'h55;
	localparam logic [13:0] MU_BIAS  = 14'h0021;
	localparam logic [13:0] MU_CLIP  = 14'h1FDE;
	localparam logic [12:0] A_BIAS   = 13'h0021;
	localparam logic [12:0] A_ROUND  = 13'h0001;
	localparam int          MU_SHIFT = 2;
	localparam int          A_SHIFT  = 3;
	localparam int          SEG_BASE = 5;

	localparam logic [15:0] STEP_MIN   = 16'h000A;
	localparam logic [15:0] STEP_MAX   = 16'h0A00;
	localparam int          STEP_UP_SH = 2;
	localparam int          STEP_DN_SH = 4;
	localparam int          LEAK_SH    = 5;
	localparam int          LP_SH      = 1;
	localparam logic signed [17:0] REF_MAX = 18'sh07FFF;
	localparam logic signed [17:0] REF_MIN = -18'sh08000;
	localparam logic [2:0]  HIST_IDLE  = 3'h2;

	localparam logic [6:0] G_SAMPLES = 7'h50;
	localparam logic [2:0] G_WORDS   = 3'h5;

	typedef enum logic [4:0] {
		ST_TAKE = 5'h01,
		ST_DEC  = 5'h02,
		ST_SRC  = 5'h04,
		ST_ENC  = 5'h08,
		ST_EMIT = 5'h10
	} state_type;

	typedef struct packed {
		logic signed [15:0] ref_v;
		logic [15:0]        step;
		logic [2:0]         hist;
	} cvsd_type;

	localparam cvsd_type CVSD_RST = '{ref_v: 16'sh0000, step: STEP_MIN, hist: HIST_IDLE};

	typedef struct packed {
		state_type          st;
		logic [15:0]        in_word;
		logic signed [15:0] lin;
		logic signed [15:0] prev;
		logic signed [15:0] cur;
		logic               half;
		logic [79:0]        gframe;
		logic [2:0]         gwords;
		logic [6:0]         gleft;
		logic [79:0]        eframe;
		logic [6:0]         ecnt;
		logic [2:0]         ewords;
		cvsd_type           dec;
		cvsd_type           enc;
		cvsd_type           gdec;
		cvsd_type           genc;
		logic signed [15:0] dflt;
		logic signed [15:0] eflt;
		logic signed [15:0] gflt;
		logic [15:0]        out_word;
		logic               mon_valid;
		logic signed [15:0] mon_data;
		logic               vad_valid;
		logic signed [15:0] vad_data;
	} chan_type;

endpackage : transcoder_pkg

// *** hdl/voice_transcoder_datapath.sv ***
// Single-channel transcoder: input decoder, rate converter, output encoder.
module voice_transcoder_datapath #(
	parameter int BUF_DEPTH = 2
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Configuration
	input  wire logic [2:0]  in_fmt_i,
	input  wire logic [2:0]  out_fmt_i,
	input  wire logic [1:0]  src_mode_i,
	input  wire logic        reverse_i,
	input  wire logic        mon_en_i,
	// Input frame words
	input  wire logic        in_valid_i,
	input  wire logic [15:0] in_data_i,
	output logic             in_ready_o,
	// Output frame words
	output logic             out_valid_o,
	output logic [15:0]      out_data_o,
	input  wire logic        out_ready_i,
	// Decoder monitor tap
	output logic             mon_valid_o,
	output logic [15:0]      mon_data_o,
	// Voice activity detector feed
	output logic             vad_valid_o,
	output logic [15:0]      vad_data_o
);

	localparam transcoder_pkg::chan_type CHAN_RST = '{
		st:   transcoder_pkg::ST_TAKE,
		dec:  transcoder_pkg::CVSD_RST,
		enc:  transcoder_pkg::CVSD_RST,
		gdec: transcoder_pkg::CVSD_RST,
		genc: transcoder_pkg::CVSD_RST,
		default: '0
	};

	transcoder_pkg::chan_type r;
	transcoder_pkg::chan_type n;
	logic [2:0]               fmt_in;
	logic [2:0]               fmt_out;
	logic                     got;
	logic                     ebit;
	logic signed [15:0]       efl;
	logic                     buf_ready;

	// [R24] standard segment tables
	// [R01] mu-law compress
	function automatic logic [7:0] mu_enc(input logic signed [15:0] s);
		logic [13:0] x;
		logic        neg;
		logic [13:0] mag;
		logic [2:0]  seg;
		logic [3:0]  man;
		x   = 14'(s >>> transcoder_pkg::MU_SHIFT);
		neg = x[13];
		mag = neg ? 14'(-x) : x;
		if (mag > transcoder_pkg::MU_CLIP) begin
			mag = transcoder_pkg::MU_CLIP;
		end
		mag = mag + transcoder_pkg::MU_BIAS;
		seg = '0;
		for (int i = 1; i < 8; i++) begin
			if (mag[i + transcoder_pkg::SEG_BASE]) begin
				seg = 3'(i);
			end
		end
		man = 4'(mag >> (seg + 3'h1));
		// [R05] invert all bits
		return {neg, seg, man} ^ transcoder_pkg::MU_MASK;
	endfunction : mu_enc

	// [R01] mu-law expand
	function automatic logic signed [15:0] mu_dec(input logic [7:0] c);
		logic [7:0]  p;
		logic [13:0] t;
		// [R05] undo inversion
		p = c ^ transcoder_pkg::MU_MASK;
		t = (14'(p[3:0]) << 1) + transcoder_pkg::MU_BIAS;
		t = (t << p[6:4]) - transcoder_pkg::MU_BIAS;
		return p[7] ? -signed'({t, 2'h0}) : signed'({t, 2'h0});
	endfunction : mu_dec

	// [R02] A-law compress
	function automatic logic [7:0] a_enc(input logic signed [15:0] s);
		logic [12:0] x;
		logic        neg;
		logic [11:0] mag;
		logic [2:0]  seg;
		logic [3:0]  man;
		x   = 13'(s >>> transcoder_pkg::A_SHIFT);
		neg = x[12];
		mag = neg ? ~x[11:0] : x[11:0];
		seg = '0;
		for (int i = 0; i < 7; i++) begin
			if (mag[i + transcoder_pkg::SEG_BASE]) begin
				seg = 3'(i + 1);
			end
		end
		man = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
		// [R04] invert even bits
		return {~neg, seg, man} ^ transcoder_pkg::A_MASK;
	endfunction : a_enc

	// [R02] A-law expand
	function automatic logic signed [15:0] a_dec(input logic [7:0] c);
		logic [7:0]  p;
		logic [12:0] t;
		// [R04] undo even inversion
		p = c ^ transcoder_pkg::A_MASK;
		t = 13'(p[3:0]) << 1;
		if (p[6:4] == 3'h0) begin
			t = t + transcoder_pkg::A_ROUND;
		end else begin
			t = (t + transcoder_pkg::A_BIAS) << (p[6:4] - 3'h1);
		end
		return p[7] ? signed'({t, 3'h0}) : -signed'({t, 3'h0});
	endfunction : a_dec

	// One slope-delta update shared by every tracking coder.
	function automatic transcoder_pkg::cvsd_type cvsd_step(
		input transcoder_pkg::cvsd_type c,
		input logic                     b
	);
		transcoder_pkg::cvsd_type o;
		logic signed [17:0]       a;
		o.hist = {c.hist[1:0], b};
		// [R09] exponential step adaptation
		if (o.hist == 3'h7 || o.hist == 3'h0) begin
			o.step = c.step + (c.step >> transcoder_pkg::STEP_UP_SH);
			if (o.step > transcoder_pkg::STEP_MAX) begin
				o.step = transcoder_pkg::STEP_MAX;
			end
		end else begin
			o.step = c.step - (c.step >> transcoder_pkg::STEP_DN_SH);
			if (o.step < transcoder_pkg::STEP_MIN) begin
				o.step = transcoder_pkg::STEP_MIN;
			end
		end
		// [R10] leaky reference integrator
		a = 18'(c.ref_v) - 18'(c.ref_v >>> transcoder_pkg::LEAK_SH);
		// [R08] add or subtract step
		if (b) begin
			a = a + $signed({2'h0, c.step});
		end else begin
			a = a - $signed({2'h0, c.step});
		end
		if (a > transcoder_pkg::REF_MAX) begin
			a = transcoder_pkg::REF_MAX;
		end else if (a < transcoder_pkg::REF_MIN) begin
			a = transcoder_pkg::REF_MIN;
		end
		o.ref_v = 16'(a);
		return o;
	endfunction : cvsd_step

	// First-order low-pass used as band-limit and postfilter.
	function automatic logic signed [15:0] lp(
		input logic signed [15:0] y,
		input logic signed [15:0] x
	);
		logic signed [16:0] d;
		d = 17'(x) - 17'(y);
		return y + 16'(d >>> transcoder_pkg::LP_SH);
	endfunction : lp

	// [R25] fixed two-tap averaging filter
	function automatic logic signed [15:0] avg(
		input logic signed [15:0] a,
		input logic signed [15:0] b
	);
		logic signed [16:0] s;
		s = 17'(a) + 17'(b);
		return 16'(s >>> 1);
	endfunction : avg

	// Where to go once a sample has been fully handled.
	function automatic transcoder_pkg::state_type after(
		input transcoder_pkg::chan_type c,
		input logic [1:0]               mode
	);
		if (mode == transcoder_pkg::SRC_INTERP && c.half) begin
			return transcoder_pkg::ST_SRC;
		end else if (c.gleft != '0) begin
			return transcoder_pkg::ST_DEC;
		end
		return transcoder_pkg::ST_TAKE;
	endfunction : after

	// [R22] reverse channel swaps formats
	assign fmt_in     = reverse_i ? out_fmt_i : in_fmt_i;
	assign fmt_out    = reverse_i ? in_fmt_i : out_fmt_i;
	assign in_ready_o = (r.st == transcoder_pkg::ST_TAKE);

	always_comb begin
		n           = r;
		got         = 1'b1;
		ebit        = 1'b0;
		efl         = r.eflt;
		n.mon_valid = 1'b0;
		n.vad_valid = 1'b0;
		case (r.st)
			transcoder_pkg::ST_TAKE: begin
				if (in_valid_i) begin
					n.in_word = in_data_i;
					n.st      = transcoder_pkg::ST_DEC;
				end
			end
			// [R14] decode to linear first
			transcoder_pkg::ST_DEC: begin
				case (fmt_in)
					// [R06] one byte per sample
					transcoder_pkg::FMT_ULAW: n.lin = mu_dec(r.in_word[7:0]);
					transcoder_pkg::FMT_ALAW: n.lin = a_dec(r.in_word[7:0]);
					// [R11] track then filter
					transcoder_pkg::FMT_CVSD: begin
						n.dec  = cvsd_step(r.dec, r.in_word[0]);
						n.dflt = lp(r.dflt, n.dec.ref_v);
						n.lin  = n.dflt;
					end
					transcoder_pkg::FMT_G729: begin
						if (r.gleft == '0) begin
							got = 1'b0;
							// [R23] five words per frame
							n.gframe = {r.gframe[63:0], r.in_word};
							if (r.gwords == transcoder_pkg::G_WORDS - 3'h1) begin
								n.gwords = '0;
								// [R17] eighty samples follow
								n.gleft = transcoder_pkg::G_SAMPLES;
								n.st    = transcoder_pkg::ST_DEC;
							end else begin
								n.gwords = r.gwords + 3'h1;
								n.st     = transcoder_pkg::ST_TAKE;
							end
						end else begin
							// [R19] synthesis then postfilter
							n.gdec   = cvsd_step(r.gdec, r.gframe[79]);
							n.gframe = r.gframe << 1;
							n.gleft  = r.gleft - 7'h1;
							n.gflt   = lp(r.gflt, n.gdec.ref_v);
							n.lin    = n.gflt;
						end
					end
					// [R16] linear at either rate
					default: n.lin = signed'(r.in_word);
				endcase
				if (got) begin
					n.st = transcoder_pkg::ST_SRC;
					// [R20] switchable monitor tap
					if (mon_en_i) begin
						n.mon_valid = 1'b1;
						n.mon_data  = n.lin;
					end
				end
			end
			// [R15] optional rate conversion
			transcoder_pkg::ST_SRC: begin
				case (src_mode_i)
					transcoder_pkg::SRC_DECIM: begin
						if (!r.half) begin
							n.prev = r.lin;
							n.half = 1'b1;
							n.st   = after(r, src_mode_i);
						end else begin
							n.cur  = avg(r.prev, r.lin);
							n.half = 1'b0;
							n.st   = transcoder_pkg::ST_ENC;
						end
					end
					transcoder_pkg::SRC_INTERP: begin
						if (!r.half) begin
							n.cur  = avg(r.prev, r.lin);
							n.half = 1'b1;
						end else begin
							n.cur  = r.lin;
							n.prev = r.lin;
							n.half = 1'b0;
						end
						n.st = transcoder_pkg::ST_ENC;
					end
					default: begin
						n.cur = r.lin;
						n.st  = transcoder_pkg::ST_ENC;
					end
				endcase
			end
			transcoder_pkg::ST_ENC: begin
				// [R21] detector fed beside encoder
				n.vad_valid = 1'b1;
				n.vad_data  = r.cur;
				n.st        = transcoder_pkg::ST_EMIT;
				case (fmt_out)
					// [R03] memoryless companding
					transcoder_pkg::FMT_ULAW: n.out_word = {8'h00, mu_enc(r.cur)};
					transcoder_pkg::FMT_ALAW: n.out_word = {8'h00, a_enc(r.cur)};
					transcoder_pkg::FMT_CVSD: begin
						// [R07] band-limit before compare
						efl    = lp(r.eflt, r.cur);
						n.eflt = efl;
						// [R13] zero input alternates
						ebit  = (efl > r.enc.ref_v);
						n.enc = cvsd_step(r.enc, ebit);
						// [R12] one bit per sample
						n.out_word = {15'h0000, ebit};
					end
					transcoder_pkg::FMT_G729: begin
						ebit     = (r.cur > r.genc.ref_v);
						n.genc   = cvsd_step(r.genc, ebit);
						n.eframe = {r.eframe[78:0], ebit};
						// [R18] eighty samples per frame
						if (r.ecnt == transcoder_pkg::G_SAMPLES - 7'h1) begin
							n.ecnt     = '0;
							n.ewords   = transcoder_pkg::G_WORDS;
							n.out_word = n.eframe[79:64];
						end else begin
							n.ecnt = r.ecnt + 7'h1;
							n.st   = after(r, src_mode_i);
						end
					end
					default: n.out_word = r.cur;
				endcase
			end
			transcoder_pkg::ST_EMIT: begin
				if (buf_ready) begin
					// [R23] frame leaves as words
					if (r.ewords > 3'h1) begin
						n.ewords   = r.ewords - 3'h1;
						n.eframe   = r.eframe << 16;
						n.out_word = n.eframe[79:64];
					end else begin
						n.ewords = '0;
						n.st     = after(r, src_mode_i);
					end
				end
			end
			default: n = CHAN_RST;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r <= CHAN_RST;
		end else begin
			r <= n;
		end
	end

	sample_buffer #(
		.WIDTH(16),
		.DEPTH(BUF_DEPTH)
	) u_out_buffer (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_valid_i(r.st == transcoder_pkg::ST_EMIT),
		.wr_data_i (r.out_word),
		.wr_ready_o(buf_ready),
		.rd_valid_o(out_valid_o),
		.rd_data_o (out_data_o),
		.rd_ready_i(out_ready_i)
	);

	assign mon_valid_o = r.mon_valid;
	assign mon_data_o  = r.mon_data;
	assign vad_valid_o = r.vad_valid;
	assign vad_data_o  = r.vad_data;

endmodule : voice_transcoder_datapath

// *** verif/host_sink.sv ***
// Output buffer model: takes words, can stall the transcoder.
module host_sink (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Control
	input  wire logic        stall_i,
	// Word stream
	input  wire logic        out_valid_i,
	input  wire logic [15:0] out_data_i,
	output logic             out_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] q[$];
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_ready_o <= 1'b0;
		end else begin
			if (out_valid_i && out_ready_o)
				q.push_back(out_data_i);
			out_ready_o <= !stall_i;
		end
	end
endmodule : host_sink

// *** verif/voice_transcoder_datapath_monitor.sv ***
// Concurrent checks on the transcoder top-level ports.
module voice_transcoder_datapath_monitor (
	// Clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	// Configuration
	input wire logic [2:0]  in_fmt_i,
	input wire logic [2:0]  out_fmt_i,
	input wire logic [1:0]  src_mode_i,
	input wire logic        reverse_i,
	input wire logic        mon_en_i,
	// Streams
	input wire logic        in_valid_i,
	input wire logic [15:0] in_data_i,
	input wire logic        in_ready_o,
	input wire logic        out_valid_o,
	input wire logic [15:0] out_data_o,
	input wire logic        out_ready_i,
	// Taps
	input wire logic        mon_valid_o,
	input wire logic [15:0] mon_data_o,
	input wire logic        vad_valid_o,
	input wire logic [15:0] vad_data_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire logic       take = in_valid_i && in_ready_o;
	wire logic [2:0] efi  = reverse_i ? out_fmt_i : in_fmt_i;
	wire logic [2:0] efo  = reverse_i ? in_fmt_i : out_fmt_i;
	a_ready_drop: assert property (take |=> !in_ready_o) else $error("ready stayed high");
	a_mon_comp: assert property (take && mon_en_i && (efi == transcoder_pkg::FMT_ULAW
		|| efi == transcoder_pkg::FMT_ALAW) |-> ##2 mon_valid_o) else $error("no mon");
	a_mon_lin: assert property (take && mon_en_i && efi == transcoder_pkg::FMT_LIN
		|-> ##2 mon_valid_o && mon_data_o == $past(in_data_i, 2)) else $error("mon");
	a_mon_off: assert property (!mon_en_i && !$past(mon_en_i, 3) |-> !mon_valid_o)
		else $error("mon while off");
	a_vad_feed: assert property (take && efi == transcoder_pkg::FMT_LIN
		&& src_mode_i == transcoder_pkg::SRC_NONE
		|-> ##4 vad_valid_o && vad_data_o == $past(in_data_i, 4)) else $error("vad");
	a_out_latency: assert property (take && !out_valid_o
		&& src_mode_i == transcoder_pkg::SRC_NONE
		&& efi != transcoder_pkg::FMT_G729 && efo != transcoder_pkg::FMT_G729
		|-> ##5 out_valid_o) else $error("late out");
	a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o
		&& $stable(out_data_o)) else $error("word lost");
	a_mon_pulse: assert property (mon_valid_o |=> !mon_valid_o) else $error("long mon");
endmodule : voice_transcoder_datapath_monitor

bind voice_transcoder_datapath voice_transcoder_datapath_monitor mon_chk (.*);

// *** verif/voice_transcoder_datapath_tb_top.sv ***
// Directed testbench for the single-channel transcoder.
module voice_transcoder_datapath_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [2:0]  in_fmt    = 3'h0;
	logic [2:0]  out_fmt   = 3'h0;
	logic [1:0]  src       = 2'h0;
	logic        rev       = 1'b0;
	logic        mon_en    = 1'b1;
	logic        in_valid  = 1'b0;
	logic        stall     = 1'b0;
	logic [15:0] in_data   = 16'h0000;
	wire logic        in_ready_o, out_valid_o, out_ready, mon_valid_o, vad_valid_o;
	wire logic [15:0] out_data_o, mon_data_o, vad_data_o;
	int bad_count = 0;
	int compares  = 0;
	int mon_n     = 0;
	int mon_base  = 0;
	logic [7:0]  exp8;
	int j;
	logic [7:0]  raw_mu [3] = '{8'h00, 8'h7F, 8'hFF};
	logic [7:0]  raw_a  [3] = '{8'h80, 8'hFF, 8'h7F};
	logic [15:0] lin    [3] = '{16'h0000, 16'h7FFF, 16'h8000};
	always #50 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (mon_valid_o === 1'b1) mon_n <= mon_n + 1;
	voice_transcoder_datapath DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_fmt_i(in_fmt),
		.out_fmt_i(out_fmt), .src_mode_i(src), .reverse_i(rev), .mon_en_i(mon_en),
		.in_valid_i(in_valid), .in_data_i(in_data), .in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready),
		.mon_valid_o(mon_valid_o), .mon_data_o(mon_data_o), .vad_valid_o(vad_valid_o),
		.vad_data_o(vad_data_o));
	host_sink sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall),
		.out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_ready_o(out_ready));
	task wrap_up;
		$display("Counts: %0d compares, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	task cmp_word(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_word
	task cmp_count(input int got, input int exp);
		compares++;
		if (got != exp) begin
			bad_count++;
			$display("ERROR t=%0t count got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_count
	task send(input logic [15:0] d);
		int i;
		@(posedge sys_clk_i);
		in_valid <= 1'b1;
		in_data  <= d;
		for (i = 0; i < 300; i++) begin
			@(negedge sys_clk_i);
			if (in_ready_o === 1'b1) break;
		end
		if (i == 300) begin
			bad_count++;
			wrap_up();
		end
		@(posedge sys_clk_i);
		in_valid <= 1'b0;
	endtask : send
	task wait_out(input int n);
		int i;
		for (i = 0; i < 3000 && sink.q.size() < n; i++) @(posedge sys_clk_i);
		repeat (40) @(posedge sys_clk_i);
		if (sink.q.size() < n) begin
			bad_count++;
			wrap_up();
		end
	endtask : wait_out
	task setup(input logic [2:0] fi, input logic [2:0] fo, input logic [1:0] s,
		input logic r, input logic m);
		repeat (10) @(posedge sys_clk_i);
		in_fmt <= fi;
		out_fmt <= fo;
		src <= s;
		rev <= r;
		mon_en <= m;
		mon_base = mon_n;
		sink.q.delete();
		repeat (4) @(posedge sys_clk_i);
	endtask : setup
	initial begin
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		// Silent input from reset gives the alternating idle pattern.
		setup(transcoder_pkg::FMT_LIN, transcoder_pkg::FMT_CVSD, transcoder_pkg::SRC_NONE, 0, 1);
		for (j = 0; j < 8; j++) send(16'h0000);
		wait_out(8);
		for (j = 0; j < 8; j++) cmp_word(sink.q[j], {15'h0000, j[0]});
		// The idle pattern fed to the decoder keeps its output near zero.
		setup(transcoder_pkg::FMT_CVSD, transcoder_pkg::FMT_LIN, transcoder_pkg::SRC_NONE, 0, 1);
		for (j = 0; j < 8; j++) send({15'h0000, !j[0]});
		wait_out(8);
		for (j = 0; j < 8; j++) cmp_count(int'(sink.q[j] <= transcoder_pkg::STEP_MIN), 1);
		$display("test cvsd_idle done");
		for (int k = 0; k < 2; k++) begin
			setup(transcoder_pkg::FMT_LIN, k ? transcoder_pkg::FMT_ALAW : transcoder_pkg::FMT_ULAW,
				transcoder_pkg::SRC_NONE, 0, 1);
			for (j = 0; j < 3; j++) send(lin[j]);
			wait_out(3);
			for (j = 0; j < 3; j++) begin
				exp8 = k ? raw_a[j] ^ transcoder_pkg::A_MASK : raw_mu[j] ^ transcoder_pkg::MU_MASK;
				cmp_word(sink.q[j], {8'h00, exp8});
			end
		end
		$display("test companding done");
		setup(transcoder_pkg::FMT_LIN, transcoder_pkg::FMT_ULAW, transcoder_pkg::SRC_NONE, 1, 1);
		send(16'h00FF);
		send(16'h007F);
		wait_out(2);
		cmp_word(sink.q[0], 16'h0000);
		cmp_word(sink.q[1], 16'h0000);
		cmp_count(mon_n - mon_base, 2);
		setup(transcoder_pkg::FMT_LIN, transcoder_pkg::FMT_ALAW, transcoder_pkg::SRC_NONE, 1, 1);
		send(16'h00D5);
		send(16'h002A);
		wait_out(2);
		cmp_word(sink.q[0], 16'h0008);
		cmp_word(sink.q[1], 16'h8200);
		$display("test reverse_decode done");
		setup(transcoder_pkg::FMT_LIN, transcoder_pkg::FMT_LIN, transcoder_pkg::SRC_DECIM, 0, 1);
		for (j = 0; j < 8; j++) send(16'(j * 256));
		wait_out(4);
		cmp_count(sink.q.size(), 4);
		cmp_word(sink.q[0], 16'h0080);
		setup(transcoder_pkg::FMT_LIN, transcoder_pkg::FMT_LIN, transcoder_pkg::SRC_INTERP, 0, 1);
		for (j = 0; j < 4; j++) send(16'h0100);
		wait_out(8);
		cmp_count(sink.q.size(), 8);
		$display("test rate_convert done");
		setup(transcoder_pkg::FMT_G729, transcoder_pkg::FMT_LIN, transcoder_pkg::SRC_NONE, 0, 1);
		for (j = 0; j < 5; j++) send(16'hA5C3);
		wait_out(80);
		cmp_count(sink.q.size(), 80);
		setup(transcoder_pkg::FMT_LIN, transcoder_pkg::FMT_G729, transcoder_pkg::SRC_NONE, 0, 1);
		for (j = 0; j < 80; j++) send(16'h0000);
		wait_out(5);
		cmp_count(sink.q.size(), 5);
		$display("test frames done");
		setup(transcoder_pkg::FMT_LIN, transcoder_pkg::FMT_LIN, transcoder_pkg::SRC_NONE, 0, 0);
		stall <= 1'b1;
		fork
			for (int m = 0; m < 4; m++) send(16'h1234 + 16'(m));
			begin
				repeat (60) @(negedge sys_clk_i);
				cmp_word({15'h0000, in_ready_o}, 16'h0000);
				@(posedge sys_clk_i);
				stall <= 1'b0;
			end
		join
		wait_out(4);
		for (j = 0; j < 4; j++) cmp_word(sink.q[j], 16'h1234 + 16'(j));
		cmp_count(mon_n - mon_base, 0);
		$display("test stall_passthrough done");
		wrap_up();
	end
endmodule : voice_transcoder_datapath_tb_top
